// File: logic/interrupt_control_regs_low.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_control_regs_low
#(
   parameter bit LARGE_VARIANT = 1'b0
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt sources, one-cycle pulses
   input wire logic comparator_zero_req,
   input wire logic comparator_one_req,
   input wire logic converter_done_req,
   input wire logic multifunc_zero_req,
   input wire logic multifunc_one_req,
   // external interrupt pins, levels
   input wire logic [2:0] ext_pin,
   // to core
   output logic irq_to_core
);
   import irq_low_pkg::*;

   // ==========================================================
   // edge detection
   edge_if e ();
   logic [7:0] edge_r;
   logic [7:0] first_r;
   logic [7:0] second_r;

   assign e.pin = ext_pin;
   assign e.sel = edge_r[5:0];

   pin_edge_detect pin_edge_detect_i
   (
      .mclk (mclk),
      .rst (rst),
      .e (e)
   );

   // ==========================================================
   // apb slave and registers
   apb_state_e state_r;
   apb_state_e state_nxt;
   logic [7:0] edge_nxt;
   logic [7:0] first_nxt;
   logic [7:0] second_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic irq_r;
   logic irq_nxt;
   logic wr;
   logic [7:0] edge_mask;

   assign edge_mask = LARGE_VARIANT ? EDGE_MASK_LARGE : EDGE_MASK_SMALL;
   // a write lands on the edge where pready is seen high
   assign wr = (state_r == ST_ACK) & psel & penable & pwrite;

   always_comb
   begin
      state_nxt = state_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (psel && penable)
            begin
               state_nxt = ST_ACK;
               pready_nxt = 1'b1;
               unique case (paddr)
                  OFS_EDGE_SEL: prdata_nxt = {24'h00_0000, edge_r};
                  OFS_CTRL_FIRST: prdata_nxt = {24'h00_0000, first_r};
                  OFS_CTRL_SECOND: prdata_nxt = {24'h00_0000, second_r};
                  default:
                  begin
                     prdata_nxt = READ_UNMAPPED;
                     pslverr_nxt = 1'b1;
                  end
               endcase
            end
         end
         ST_ACK: state_nxt = ST_IDLE;
      endcase
   end

   always_comb
   begin
      edge_nxt = edge_r;
      first_nxt = first_r;
      second_nxt = second_r;
      if (wr && paddr == OFS_EDGE_SEL)
         edge_nxt = pwdata[7:0] & edge_mask;
      if (wr && paddr == OFS_CTRL_FIRST)
         first_nxt = pwdata[7:0] & FIRST_MASK;
      if (wr && paddr == OFS_CTRL_SECOND)
         second_nxt = pwdata[7:0];
      // hardware sets are applied after the write so a set beats a clear
      first_nxt[EXT_PIN_ZERO_FLAG] = first_nxt[EXT_PIN_ZERO_FLAG] | e.hit[0];
      first_nxt[EXT_PIN_ONE_FLAG] = first_nxt[EXT_PIN_ONE_FLAG] | e.hit[1];
      if (LARGE_VARIANT)
         first_nxt[SHARED_FLAG] = first_nxt[SHARED_FLAG] | e.hit[2];
      else
         first_nxt[SHARED_FLAG] = first_nxt[SHARED_FLAG] | comparator_zero_req;
      second_nxt[CONVERTER_DONE_FLAG] = second_nxt[CONVERTER_DONE_FLAG]
         | converter_done_req;
      second_nxt[COMPARATOR_ONE_FLAG] = second_nxt[COMPARATOR_ONE_FLAG]
         | comparator_one_req;
      second_nxt[MULTIFUNC_ZERO_FLAG] = second_nxt[MULTIFUNC_ZERO_FLAG]
         | multifunc_zero_req;
      second_nxt[MULTIFUNC_ONE_FLAG] = second_nxt[MULTIFUNC_ONE_FLAG]
         | multifunc_one_req;
      // enables sit three (first) or four (second) bits below their flags
      irq_nxt = first_r[GLOBAL_IRQ_ENABLE]
         & ((|(first_r[SHARED_ENABLE:EXT_PIN_ZERO_ENABLE]
               & first_r[SHARED_FLAG:EXT_PIN_ZERO_FLAG]))
            | (|(second_r[CONVERTER_DONE_ENABLE:COMPARATOR_ONE_ENABLE]
               & second_r[CONVERTER_DONE_FLAG:COMPARATOR_ONE_FLAG])));
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         edge_r <= RST_VAL;
         first_r <= RST_VAL;
         second_r <= RST_VAL;
         prdata_r <= READ_UNMAPPED;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         edge_r <= edge_nxt;
         first_r <= first_nxt;
         second_r <= second_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq_to_core = irq_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   logic [2:0] second_src;
   assign second_src = {multifunc_one_req, multifunc_zero_req, comparator_one_req};

   property p_cmp0_flag;
      (!LARGE_VARIANT && comparator_zero_req) |=> first_r[SHARED_FLAG];
   endproperty
   a_cmp0_flag: assert property (p_cmp0_flag) else $error("comparator0 flag not set");

   property p_pin1_flag;
      e.hit[1] |=> first_r[EXT_PIN_ONE_FLAG] ##1 1'b1;
   endproperty
   a_pin1_flag: assert property (p_pin1_flag) else $error("pin1 flag not set");

   property p_pin0_flag;
      e.hit[0] |=> first_r[EXT_PIN_ZERO_FLAG];
   endproperty
   a_pin0_flag: assert property (p_pin0_flag) else $error("pin0 flag not set");

   property p_pin2_flag;
      (LARGE_VARIANT && e.hit[2]) |=> first_r[SHARED_FLAG];
   endproperty
   a_pin2_flag: assert property (p_pin2_flag) else $error("pin2 flag not set");

   // the shared flag must only follow the source that the variant owns
   property p_shared_quiet;
      (!first_r[SHARED_FLAG] && !wr
         && !(LARGE_VARIANT ? e.hit[2] : comparator_zero_req)) |=> !first_r[SHARED_FLAG];
   endproperty
   a_shared_quiet: assert property (p_shared_quiet) else $error("shared flag set");

   property p_conv_flag;
      converter_done_req |-> ##1 second_r[CONVERTER_DONE_FLAG];
   endproperty
   a_conv_flag: assert property (p_conv_flag) else $error("converter flag not set");

   property p_second_flags;
      (|second_src) |=> (second_r[MULTIFUNC_ONE_FLAG:COMPARATOR_ONE_FLAG]
         & $past(second_src)) == $past(second_src);
   endproperty
   a_second_flags: assert property (p_second_flags) else $error("second flags not set");

   property p_rise_detect;
      (edge_r[1:0] == EDGE_RISE && !$past(ext_pin[0]) && ext_pin[0] && !$past(rst))
         |-> e.hit[0] ##1 first_r[EXT_PIN_ZERO_FLAG];
   endproperty
   a_rise_detect: assert property (p_rise_detect) else $error("rising edge missed");

   property p_gate;
      !first_r[GLOBAL_IRQ_ENABLE] |=> !irq_r;
   endproperty
   a_gate: assert property (p_gate) else $error("irq without global enable");

   property p_forward;
      (first_r[GLOBAL_IRQ_ENABLE] && second_r[COMPARATOR_ONE_ENABLE]
         && second_r[COMPARATOR_ONE_FLAG]) |=> irq_r;
   endproperty
   a_forward: assert property (p_forward) else $error("enabled request not forwarded");
endmodule : interrupt_control_regs_low
`default_nettype wire

// File: logic/irq_low_pkg.sv
`default_nettype none
package irq_low_pkg;
   // apb word offsets
   localparam logic [11:0] OFS_EDGE_SEL = 12'h000;
   localparam logic [11:0] OFS_CTRL_FIRST = 12'h004;
   localparam logic [11:0] OFS_CTRL_SECOND = 12'h008;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
   // reset values and writable masks
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [7:0] FIRST_MASK = 8'h7F;
   localparam logic [7:0] EDGE_MASK_SMALL = 8'h0F;
   localparam logic [7:0] EDGE_MASK_LARGE = 8'h3F;
   // first control register fields
   localparam int GLOBAL_IRQ_ENABLE = 0;
   localparam int EXT_PIN_ZERO_ENABLE = 1;
   localparam int EXT_PIN_ONE_ENABLE = 2;
   localparam int SHARED_ENABLE = 3;
   localparam int EXT_PIN_ZERO_FLAG = 4;
   localparam int EXT_PIN_ONE_FLAG = 5;
   localparam int SHARED_FLAG = 6;
   // second control register fields
   localparam int COMPARATOR_ONE_ENABLE = 0;
   localparam int MULTIFUNC_ZERO_ENABLE = 1;
   localparam int MULTIFUNC_ONE_ENABLE = 2;
   localparam int CONVERTER_DONE_ENABLE = 3;
   localparam int COMPARATOR_ONE_FLAG = 4;
   localparam int MULTIFUNC_ZERO_FLAG = 5;
   localparam int MULTIFUNC_ONE_FLAG = 6;
   localparam int CONVERTER_DONE_FLAG = 7;
   // edge select codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam int NUM_PINS = 3;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b10} apb_state_e;
endpackage : irq_low_pkg
`default_nettype wire

// File: logic/edge_if.sv
`timescale 1ns/100ps
`default_nettype none
interface edge_if;
   logic [2:0] pin;
   logic [5:0] sel;
   logic [2:0] hit;
   modport ctrl (output pin, output sel, input hit);
   modport det (input pin, input sel, output hit);
endinterface : edge_if
`default_nettype wire

// File: logic/pin_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pins, selects and hits
   edge_if.det e
);
   import irq_low_pkg::*;

   logic [2:0] prev_r;
   logic [2:0] prev_nxt;
   logic valid_r;
   logic valid_nxt;

   always_comb
   begin
      prev_nxt = e.pin;
      valid_nxt = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         prev_r <= 3'h0;
         valid_r <= 1'b0;
      end
      else
      begin
         prev_r <= prev_nxt;
         valid_r <= valid_nxt;
      end
   end

   // the first cycle after reset has no history, so no edge is claimed
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++)
      begin : g_pin
         logic rise;
         logic fall;
         logic hit;
         assign rise = valid_r & e.pin[g] & ~prev_r[g];
         assign fall = valid_r & ~e.pin[g] & prev_r[g];
         // one process per bit would share the vector, so each bit has its own local
         assign e.hit[g] = hit;
         always_comb
         begin
            unique case (e.sel[2*g+1 -: 2])
               EDGE_OFF: hit = 1'b0;
               EDGE_RISE: hit = rise;
               EDGE_FALL: hit = fall;
               EDGE_BOTH: hit = rise | fall;
            endcase
         end
      end
   endgenerate
endmodule : pin_edge_detect
`default_nettype wire

// File: testbench/irq_source_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// far-side interrupt sources
module irq_source_model
(
   // clock
   input wire logic mclk,
   // command from bench
   input wire logic [4:0] fire,
   // requests: cmp0, cmp1, mf0, mf1, conv
   output logic [4:0] req
);
   // registered so each request is one clean mclk-wide pulse
   always_ff @(posedge mclk)
   begin
      req <= fire;
   end
endmodule : irq_source_model
`default_nettype wire

// File: testbench/interrupt_control_regs_low_bench.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_control_regs_low_bench;
   import irq_low_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq_to_core;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] ext_pin;
   logic [4:0] fire, req;
   logic e;
   logic psel_l, pready_l, pslverr_l, irq_l, big;
   logic [31:0] prdata_l;
   int n_fail, n_compared;
   logic [7:0] ef [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] es [5] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h80};
   interrupt_control_regs_low interrupt_control_regs_low_i (.mclk(mclk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_zero_req(req[0]),
      .comparator_one_req(req[1]), .multifunc_zero_req(req[2]), .multifunc_one_req(req[3]),
      .converter_done_req(req[4]), .ext_pin(ext_pin), .irq_to_core(irq_to_core));
   irq_source_model irq_source_model_i (.mclk(mclk), .fire(fire), .req(req));
   // second slave on the same bus: the large variant, selected by psel_l
   interrupt_control_regs_low #(.LARGE_VARIANT(1'b1)) interrupt_control_regs_low_large_i (
      .mclk(mclk), .rst(rst), .psel(psel_l), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata_l), .pready(pready_l), .pslverr(pslverr_l),
      .comparator_zero_req(req[0]), .comparator_one_req(req[1]), .multifunc_zero_req(req[2]),
      .multifunc_one_req(req[3]), .converter_done_req(req[4]), .ext_pin(ext_pin),
      .irq_to_core(irq_l));
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ====================
   // helpers
   task automatic end_of_test;
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one idle cycle between transfers keeps psel from being assigned twice per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= !big;
      psel_l <= big;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while ((big ? pready_l : pready) !== 1'b1 && k < 50);
      if (k >= 50)
         n_fail++;
      q = big ? prdata_l : prdata;
      e = big ? pslverr_l : pslverr;
      psel <= 1'b0;
      psel_l <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, {24'h00_0000, exp});
      chk({31'h0, e}, 32'h0000_0000);
   endtask : rd
   task automatic pulse(input int i);
      @(posedge mclk);
      fire <= 5'h01 << i;
      @(posedge mclk);
      fire <= 5'h00;
      repeat (3) @(posedge mclk);
   endtask : pulse
   // ====================
   // tests
   initial
   begin
      rst = 1'b1;
      {psel, psel_l, big, penable, pwrite, paddr, pwdata, ext_pin, fire} = '0;
      n_fail = 0;
      n_compared = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      rd(OFS_EDGE_SEL, 8'h00);
      rd(OFS_CTRL_FIRST, 8'h00);
      rd(OFS_CTRL_SECOND, 8'h00);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(q, READ_UNMAPPED);
      chk({31'h0, e}, 32'h0000_0001);
      wr(OFS_CTRL_FIRST, 8'hFF);
      rd(OFS_CTRL_FIRST, 8'h7F);
      wr(OFS_CTRL_SECOND, 8'hFF);
      rd(OFS_CTRL_SECOND, 8'hFF);
      wr(OFS_CTRL_FIRST, 8'h00);
      wr(OFS_CTRL_SECOND, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         pulse(i);
         rd(OFS_CTRL_FIRST, ef[i]);
         rd(OFS_CTRL_SECOND, es[i]);
         wr(OFS_CTRL_FIRST, 8'h00);
         wr(OFS_CTRL_SECOND, 8'h00);
      end
      // pin 2 toggles too: the small variant must not flag it
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_EDGE_SEL, {4'h0, c[1:0], c[1:0]});
         @(posedge mclk);
         ext_pin <= 3'b111;
         repeat (3) @(posedge mclk);
         rd(OFS_CTRL_FIRST, c[0] ? 8'h30 : 8'h00);
         wr(OFS_CTRL_FIRST, 8'h00);
         @(posedge mclk);
         ext_pin <= 3'b000;
         repeat (3) @(posedge mclk);
         rd(OFS_CTRL_FIRST, c[1] ? 8'h30 : 8'h00);
         wr(OFS_CTRL_FIRST, 8'h00);
      end
      wr(OFS_CTRL_FIRST, 8'h01);
      pulse(2);
      chk({31'h0, irq_to_core}, 32'h0000_0000);
      wr(OFS_CTRL_SECOND, 8'h01);
      pulse(1);
      chk({31'h0, irq_to_core}, 32'h0000_0001);
      wr(OFS_CTRL_FIRST, 8'h00);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq_to_core}, 32'h0000_0000);
      wr(OFS_EDGE_SEL, 8'hFF);
      rd(OFS_EDGE_SEL, 8'h0F);
      // large variant: pin 2 owns the shared bits, so the earlier comparator 0 pulse left none
      big = 1'b1;
      rd(OFS_CTRL_FIRST, 8'h00);
      wr(OFS_EDGE_SEL, 8'hFF);
      rd(OFS_EDGE_SEL, 8'h3F);
      wr(OFS_EDGE_SEL, 8'h10);
      wr(OFS_CTRL_FIRST, 8'h09);
      @(posedge mclk);
      ext_pin <= 3'b100;
      repeat (3) @(posedge mclk);
      rd(OFS_CTRL_FIRST, 8'h49);
      chk({31'h0, irq_l}, 32'h0000_0001);
      end_of_test;
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_of_test;
   end
endmodule : interrupt_control_regs_low_bench
`default_nettype wire
